// ===== sil_pkg.sv
// Constants and types for the status indicator logic
package sil_pkg;
  localparam int unsigned CLOCK_HZ        = 50000000;
  localparam int unsigned SELFTEST_MS     = 1000;
  localparam int unsigned SELFTEST_CYCLES = CLOCK_HZ / 1000 * SELFTEST_MS;
  localparam int unsigned FLASH_MS        = 500;
  localparam int unsigned FLASH_CYCLES    = CLOCK_HZ / 1000 * FLASH_MS;
  localparam int unsigned CNT_W           = 26;

  typedef enum logic [1:0] {
    LAMP_OFF,
    LAMP_GREEN,
    LAMP_RED
  } sil_colour_type;

  typedef enum logic [2:0] {
    LINK_OFFLINE,
    LINK_ONLINE,
    LINK_CONNECTED,
    LINK_TIMEOUT,
    LINK_ERROR
  } sil_link_type;
endpackage

// ===== sil_flash_if.sv
// Flash timing signals shared between the timer and the lamp logic
`timescale 1ns/1ps
`default_nettype none
interface sil_flash_if;
  logic testDone;
  logic flashPhase;
  modport timer (output testDone, output flashPhase);
  modport user  (input testDone, input flashPhase);
endinterface
`default_nettype wire

// ===== sil_flash_timer.sv
// Self-test and flash phase timer
`timescale 1ns/1ps
`default_nettype none
module sil_flash_timer #(
  parameter int unsigned SELFTEST_CYCLES = sil_pkg::SELFTEST_CYCLES,
  parameter int unsigned FLASH_CYCLES    = sil_pkg::FLASH_CYCLES
) (
  input  wire logic   clock,
  input  wire logic   resetn,
  sil_flash_if.timer  flash
);
  logic [sil_pkg::CNT_W-1:0] testCnt_reg;
  logic [sil_pkg::CNT_W-1:0] flashCnt_reg;
  logic                      done_reg;
  logic                      phase_reg;

  // ----------------------------------------
  // Self-test window
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      testCnt_reg <= '0;
      done_reg    <= 1'b0;
    end else if (!done_reg) begin
      if (testCnt_reg == sil_pkg::CNT_W'(SELFTEST_CYCLES - 1)) begin
        done_reg <= 1'b1;
      end
      testCnt_reg <= testCnt_reg + 1'b1;
    end
  end

  // ----------------------------------------
  // Flash phase, 1 Hz square wave
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      flashCnt_reg <= '0;
      phase_reg    <= 1'b0;
    end else if (flashCnt_reg == sil_pkg::CNT_W'(FLASH_CYCLES - 1)) begin
      flashCnt_reg <= '0;
      phase_reg    <= ~phase_reg;
    end else begin
      flashCnt_reg <= flashCnt_reg + 1'b1;
    end
  end

  assign flash.testDone   = done_reg;
  assign flash.flashPhase = phase_reg;
endmodule // sil_flash_timer
`default_nettype wire

// ===== sil_status_lamps.sv
// Module-health and network-link lamp driver with host alarms
`timescale 1ns/1ps
`default_nettype none
module sil_status_lamps #(
  parameter int unsigned SELFTEST_CYCLES = sil_pkg::SELFTEST_CYCLES,
  parameter int unsigned FLASH_CYCLES    = sil_pkg::FLASH_CYCLES
) (
  input  wire logic              clock,
  input  wire logic              resetn,
  input  wire logic              hwFault,
  input  wire logic              linkOnline,
  input  wire logic              linkConnected,
  input  wire logic              linkTimeout,
  input  wire logic              linkError,
  input  wire logic              alarmSuppress,
  input  wire logic              alarmClear,
  output logic                   healthGreen,
  output logic                   healthRed,
  output logic                   linkGreen,
  output logic                   linkRed,
  output logic                   optionFaultAlarm,
  output logic                   networkFaultAlarm
);
  sil_flash_if flash ();

  sil_flash_timer #(
    .SELFTEST_CYCLES (SELFTEST_CYCLES),
    .FLASH_CYCLES    (FLASH_CYCLES)
  ) u_timer (
    .clock  (clock),
    .resetn (resetn),
    .flash  (flash)
  );

  sil_pkg::sil_link_type linkState;
  logic                  linkSteadyGreen;

  // ----------------------------------------
  // Link state priority
  // ----------------------------------------
  always_comb begin
    if (linkError) begin
      linkState = sil_pkg::LINK_ERROR;
    end else if (linkTimeout) begin
      linkState = sil_pkg::LINK_TIMEOUT;
    end else if (linkConnected) begin
      linkState = sil_pkg::LINK_CONNECTED;
    end else if (linkOnline) begin
      linkState = sil_pkg::LINK_ONLINE;
    end else begin
      linkState = sil_pkg::LINK_OFFLINE;
    end
  end

  assign linkSteadyGreen = flash.testDone && (linkState == sil_pkg::LINK_CONNECTED);

  // ----------------------------------------
  // Module-health lamp
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      healthGreen <= 1'b0;
      healthRed   <= 1'b0;
    end else if (!flash.testDone) begin
      healthGreen <= ~flash.flashPhase;
      healthRed   <= flash.flashPhase;
    end else begin
      healthGreen <= ~hwFault;
      healthRed   <= hwFault;
    end
  end

  // ----------------------------------------
  // Option-fault alarm
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      optionFaultAlarm <= 1'b0;
    end else begin
      optionFaultAlarm <= flash.testDone && hwFault;
    end
  end

  // ----------------------------------------
  // Network-link lamp
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      linkGreen <= 1'b0;
      linkRed   <= 1'b0;
    end else if (!flash.testDone) begin
      linkGreen <= ~flash.flashPhase;
      linkRed   <= flash.flashPhase;
    end else begin
      unique case (linkState)
        sil_pkg::LINK_OFFLINE: begin
          linkGreen <= 1'b0;
          linkRed   <= 1'b0;
        end
        sil_pkg::LINK_ONLINE: begin
          linkGreen <= flash.flashPhase;
          linkRed   <= 1'b0;
        end
        sil_pkg::LINK_CONNECTED: begin
          linkGreen <= 1'b1;
          linkRed   <= 1'b0;
        end
        sil_pkg::LINK_TIMEOUT: begin
          linkGreen <= 1'b0;
          linkRed   <= flash.flashPhase;
        end
        sil_pkg::LINK_ERROR: begin
          linkGreen <= 1'b0;
          linkRed   <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Network-fault alarm, latched
  // ----------------------------------------
  // Set beats clear so a fresh fault is never lost
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      networkFaultAlarm <= 1'b0;
    end else if (flash.testDone && !alarmSuppress &&
                 (linkState == sil_pkg::LINK_TIMEOUT || linkState == sil_pkg::LINK_ERROR)) begin
      networkFaultAlarm <= 1'b1;
    end else if (alarmClear && linkSteadyGreen) begin
      networkFaultAlarm <= 1'b0;
    end
  end
endmodule // sil_status_lamps
`default_nettype wire

// ===== sil_lamps_props.sv
// Checker for the status lamp outputs
`timescale 1ns/1ps
`default_nettype none
module sil_lamps_props #(parameter int unsigned SELFTEST_CYCLES = sil_pkg::SELFTEST_CYCLES) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic hwFault,
  input wire logic linkOnline,
  input wire logic linkConnected,
  input wire logic linkTimeout,
  input wire logic linkError,
  input wire logic alarmSuppress,
  input wire logic healthGreen,
  input wire logic healthRed,
  input wire logic linkGreen,
  input wire logic linkRed,
  input wire logic optionFaultAlarm,
  input wire logic networkFaultAlarm
);
  int unsigned cnt_reg;
  logic        done;
  logic        ok;
  // Margin past the self-test, since its last edge is not pinned down
  assign done = cnt_reg > SELFTEST_CYCLES + 2;
  assign ok = linkConnected && !linkTimeout && !linkError;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) cnt_reg <= 0;
    else if (!done) cnt_reg <= cnt_reg + 1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  self_alt_a: assert property (cnt_reg > 0 && cnt_reg < SELFTEST_CYCLES - 1 |->
    healthGreen != healthRed && linkGreen == healthGreen) else $error("self");
  self_flash_a: assert property ($rose(healthRed) && cnt_reg < SELFTEST_CYCLES - 5
    |=> healthRed [*3]) else $error("flash");
  health_a: assert property (done |=> healthRed == $past(hwFault) && healthGreen == !healthRed)
    else $error("health");
  opt_alarm_a: assert property (done |=> optionFaultAlarm == $past(hwFault)) else $error("opt");
  link_dark_a: assert property (done && !linkOnline && !ok && !linkTimeout && !linkError
    |=> !linkGreen && !linkRed) else $error("dark");
  link_green_a: assert property (done && ok |=> linkGreen && !linkRed) else $error("green");
  link_blink_a: assert property (done && linkOnline && !linkConnected && !linkTimeout
    && !linkError |=> !linkRed) else $error("blink");
  link_tout_a: assert property (done && linkTimeout && !linkError
    |=> !linkGreen) else $error("tout");
  link_red_a: assert property (done && linkError |=> linkRed && !linkGreen) else $error("red");
  alarm_set_a: assert property (done && (linkTimeout || linkError) && !alarmSuppress
    |=> networkFaultAlarm) else $error("set");
  alarm_hold_a: assert property (networkFaultAlarm && !ok |=> networkFaultAlarm) else $error("hold");
  alarm_mute_a: assert property (alarmSuppress && !networkFaultAlarm |=> !networkFaultAlarm)
    else $error("mute");
endmodule // sil_lamps_props
bind sil_status_lamps sil_lamps_props #(.SELFTEST_CYCLES(SELFTEST_CYCLES)) chk (.*);
`default_nettype wire

// ===== sil_link_partner.sv
// Network partner model giving the link state as level flags
`timescale 1ns/1ps
`default_nettype none
module sil_link_partner (
  input  wire sil_pkg::sil_link_type mode,
  output logic                       linkOnline,
  output logic                       linkConnected,
  output logic                       linkTimeout,
  output logic                       linkError
);
  // One flag at a time, as the master reports one state
  assign linkOnline = mode == sil_pkg::LINK_ONLINE;
  assign linkConnected = mode == sil_pkg::LINK_CONNECTED;
  assign linkTimeout = mode == sil_pkg::LINK_TIMEOUT;
  assign linkError = mode == sil_pkg::LINK_ERROR;
endmodule // sil_link_partner
`default_nettype wire

// ===== status_indicator_logic_tb_top.sv
// Self-checking bench for the status lamp logic
`timescale 1ns/1ps
`default_nettype none
module status_indicator_logic_tb_top;
  localparam logic [7:0] ON = 8'h04;
  localparam logic [7:0] FULL = 2 * ON;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic hwFault = 1'b0;
  logic alarmSuppress = 1'b0;
  logic alarmClear = 1'b0;
  sil_pkg::sil_link_type mode = sil_pkg::LINK_OFFLINE;
  logic linkOnline, linkConnected, linkTimeout, linkError;
  logic healthGreen, healthRed, linkGreen, linkRed, optionFaultAlarm, networkFaultAlarm;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  logic [7:0] g, r, h;
  always #10 clock = ~clock;
  sil_status_lamps #(.SELFTEST_CYCLES(40), .FLASH_CYCLES(ON)) uut (.*);
  sil_link_partner pm (.*);
  task close_out;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Counts lit cycles over one full flash period, so blink phase does not matter
  task run(input sil_pkg::sil_link_type m, input logic c, input logic [31:0] e);
    @(posedge clock);
    mode <= m;
    alarmClear <= c;
    repeat (2) @(posedge clock);
    {g, r, h} = 24'h000000;
    repeat (2 * ON) begin
      @(posedge clock);
      #1;
      h += healthRed;
      g += linkGreen;
      r += linkRed;
    end
    chk({h, g, r, 6'h00, optionFaultAlarm, networkFaultAlarm}, e);
  endtask
  task t_selftest;
    run(sil_pkg::LINK_OFFLINE, 1'b0, {ON, ON, ON, 8'h00});
    repeat (40) @(posedge clock);
  endtask
  task t_health;
    @(posedge clock);
    hwFault <= 1'b1;
    run(sil_pkg::LINK_OFFLINE, 1'b0, {FULL, 24'h000002});
    @(posedge clock);
    hwFault <= 1'b0;
    run(sil_pkg::LINK_OFFLINE, 1'b0, 32'h00000000);
  endtask
  task t_link;
    run(sil_pkg::LINK_ONLINE, 1'b0, {8'h00, ON, 16'h0000});
    run(sil_pkg::LINK_CONNECTED, 1'b0, {8'h00, FULL, 16'h0000});
    run(sil_pkg::LINK_TIMEOUT, 1'b0, {16'h0000, ON, 8'h01});
    run(sil_pkg::LINK_CONNECTED, 1'b0, {8'h00, FULL, 16'h0001});
    run(sil_pkg::LINK_ERROR, 1'b1, {16'h0000, FULL, 8'h01});
    run(sil_pkg::LINK_CONNECTED, 1'b1, {8'h00, FULL, 16'h0000});
  endtask
  task t_mute;
    @(posedge clock);
    alarmSuppress <= 1'b1;
    run(sil_pkg::LINK_ERROR, 1'b0, {16'h0000, FULL, 8'h00});
    run(sil_pkg::LINK_TIMEOUT, 1'b0, {16'h0000, ON, 8'h00});
  endtask
  initial begin
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    t_selftest;
    t_health;
    t_link;
    t_mute;
    close_out;
  end
  // Run needs under two hundred cycles; the ceiling leaves ample slack
  always @(posedge clock) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      close_out;
    end
  end
endmodule // status_indicator_logic_tb_top
`default_nettype wire
